// file: bench/tms_timer0_tb.sv
/*
 * Self-checking bench for the timer 0 register block: register access, forced
 * compares, flags, requests, clock select and the count pin.
 * Assumes tms_pkg and tms_timer0 are compiled first; bench drives every port.
 */
`timescale 1ns/10ps
module tms_timer0_tb
	import tms_pkg::*;
;
	logic        clock;
	logic        nrst;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbWrData;
	logic [31:0] wbRdData;
	logic        wbAck;
	logic        extCountPin;
	logic        compareOutA;
	logic        compareOutB;
	logic        compareOutAEn;
	logic        compareOutBEn;
	logic        gie;
	logic [2:0]  irqAck;
	logic [2:0]  irqReq;
	logic [7:0]  v;
	int          errCount;
	int          checked;

	always #25 clock = ~clock;

	tms_timer0 dut_u (
		.clock           (clock),
		.nrst            (nrst),
		.wbCyc           (wbCyc),
		.wbStb           (wbStb),
		.wbWe            (wbWe),
		.wbAdr           (wbAdr),
		.wbSel           (wbSel),
		.wbWrData        (wbWrData),
		.wbRdData        (wbRdData),
		.wbAck           (wbAck),
		.extCountPin     (extCountPin),
		.compareOutA     (compareOutA),
		.compareOutB     (compareOutB),
		.compareOutAEn   (compareOutAEn),
		.compareOutBEn   (compareOutBEn),
		.globalIrqEnable (gie),
		.irqAck          (irqAck),
		.irqReq          (irqReq)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One classic cycle; ack sampled at the edge, values read before they drop
	task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rdv);
		int n;
		@(posedge clock);
		wbCyc    <= 1'b1;
		wbStb    <= 1'b1;
		wbWe     <= we;
		wbAdr    <= {idx, 2'b00};
		wbSel    <= 4'h1;
		wbWrData <= {24'h0, wd};
		for (n = 0; n < 20 && wbAck !== 1'b1; n++) begin
			@(posedge clock);
		end
		rdv = wbRdData[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		if (n == 20) begin
			errCount++;
			final_report();
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] junk;
		xfer(1'b1, idx, d, junk);
	endtask

	task automatic rd(input logic [5:0] idx);
		xfer(1'b0, idx, 8'h00, v);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(IDX_CTRL_B);
		check("ctrlb reset", v, 8'h00);
		rd(IDX_FLAGS);
		check("flags reset", v, 8'h00);
		wr(IDX_MASK, 8'hff);
		rd(IDX_MASK);
		check("mask rsv", v, 8'h07);
		wr(IDX_CTRL_B, 8'h38);
		rd(IDX_CTRL_B);
		check("ctrlb rsv", v, 8'h08);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_CMP_B, 8'ha5);
		rd(IDX_CMP_B);
		check("cmpb rw", v, 8'ha5);
		wr(IDX_COUNT, 8'h5a);
		rd(IDX_COUNT);
		check("count rw", v, 8'h5a);
		wr(IDX_FLAGS, 8'hf8);
		rd(IDX_FLAGS);
		check("flags rsv", v, 8'h00);
		// Unmapped slot must ack, ignore data and read zero
		wr(6'h00, 8'hff);
		rd(6'h00);
		check("unmapped", v, 8'h00);
		wr(IDX_MASK, 8'h00);
	endtask

	task automatic t_force();
		logic e;
		wr(IDX_CMP_A, 8'h80);
		wr(IDX_COUNT, 8'h00);
		for (int m = 1; m < 4; m++) begin
			wr(IDX_CTRL_A, {m[1:0], m[1:0], 4'h0});
			e = (m == 1) ? ~compareOutA : m[0];
			wr(IDX_CTRL_B, 8'h80);
			check("force A", compareOutA, e);
			e = (m == 1) ? ~compareOutB : m[0];
			wr(IDX_CTRL_B, 8'h40);
			check("force B", compareOutB, e);
			check("enable A", compareOutAEn, 1'b1);
			check("enable B", compareOutBEn, 1'b1);
		end
		rd(IDX_CTRL_B);
		check("force reads 0", v, 8'h00);
		rd(IDX_FLAGS);
		check("force no flag", v, 8'h00);
		check("force no req", irqReq, 3'b000);
		// CTC with compare A as top: a force must not clear the count
		wr(IDX_CTRL_A, 8'hc2);
		wr(IDX_COUNT, 8'h80);
		wr(IDX_CTRL_B, 8'h80);
		rd(IDX_COUNT);
		check("ctc no clear", v, 8'h80);
		// Fast PWM: output is set, a clear-mode force must be ignored
		wr(IDX_CTRL_A, 8'h83);
		wr(IDX_CTRL_B, 8'hc0);
		check("pwm force", compareOutA, 1'b1);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_CTRL_A, 8'h00);
		check("enable off", compareOutAEn, 1'b0);
		check("enable B off", compareOutBEn, 1'b0);
	endtask

	task automatic t_overflow();
		wr(IDX_FLAGS, 8'h07);
		wr(IDX_MASK, 8'h01);
		gie <= 1'b1;
		wr(IDX_COUNT, 8'hfe);
		wr(IDX_CTRL_B, {5'h0, CS_DIV1});
		repeat (4) @(posedge clock);
		wr(IDX_CTRL_B, 8'h00);
		rd(IDX_FLAGS);
		check("ovf flag", v, 8'h01);
		check("ovf req", irqReq, 3'b001);
		gie <= 1'b0;
		repeat (3) @(posedge clock);
		check("gie gates", irqReq, 3'b000);
		gie <= 1'b1;
		wr(IDX_FLAGS, 8'h00);
		rd(IDX_FLAGS);
		check("w0 keeps", v, 8'h01);
		wr(IDX_FLAGS, 8'h01);
		rd(IDX_FLAGS);
		check("w1 clears", v, 8'h00);
		check("req drops", irqReq, 3'b000);
	endtask

	task automatic t_match();
		wr(IDX_MASK, 8'h02);
		wr(IDX_CMP_A, 8'h10);
		wr(IDX_CMP_B, 8'h12);
		wr(IDX_COUNT, 8'h0e);
		wr(IDX_CTRL_B, {5'h0, CS_DIV1});
		repeat (4) @(posedge clock);
		wr(IDX_CTRL_B, 8'h00);
		rd(IDX_FLAGS);
		check("match flags", v, 8'h06);
		check("masked req", irqReq, 3'b010);
		irqAck <= 3'b010;
		@(posedge clock);
		irqAck <= 3'b000;
		rd(IDX_FLAGS);
		check("vector clear", v, 8'h04);
		// Counter written to the compare A value while running: no compare A match
		wr(IDX_FLAGS, 8'h07);
		wr(IDX_CMP_A, 8'h40);
		wr(IDX_CMP_B, 8'h42);
		wr(IDX_COUNT, 8'h00);
		wr(IDX_CTRL_B, {5'h0, CS_DIV1});
		wr(IDX_COUNT, 8'h40);
		repeat (4) @(posedge clock);
		wr(IDX_CTRL_B, 8'h00);
		rd(IDX_FLAGS);
		check("write blocks", v, 8'h04);
		wr(IDX_FLAGS, 8'h07);
	endtask

	// CTC wraps at compare A; real matches drive both outputs
	task automatic t_ctc();
		logic e;
		wr(IDX_FLAGS, 8'h07);
		wr(IDX_CMP_A, 8'h05);
		wr(IDX_CMP_B, 8'h03);
		wr(IDX_CTRL_A, 8'h62);
		wr(IDX_COUNT, 8'h00);
		// Three compare A matches in the run, so A ends inverted
		e = ~compareOutA;
		wr(IDX_CTRL_B, {5'h0, CS_DIV1});
		repeat (20) @(posedge clock);
		wr(IDX_CTRL_B, 8'h00);
		check("ctc toggles", compareOutA, e);
		check("ctc clears", compareOutB, 1'b0);
		rd(IDX_COUNT);
		check("ctc wrap", v, 8'h05);
		rd(IDX_FLAGS);
		check("ctc flags", v, 8'h06);
		wr(IDX_CTRL_A, 8'h00);
		wr(IDX_FLAGS, 8'h07);
	endtask

	task automatic t_presc();
		int divs [6] = '{0, 1, 8, 64, 256, 1024};
		int lo;
		int hi;
		for (int c = 0; c < 6; c++) begin
			lo = (c == 0) ? 0 : 19;
			hi = (c == 0) ? 0 : ((c == 1) ? 26 : 21);
			wr(IDX_COUNT, 8'h00);
			wr(IDX_CTRL_B, c[7:0]);
			repeat ((c == 0) ? 50 : 20 * divs[c]) @(posedge clock);
			wr(IDX_CTRL_B, 8'h00);
			rd(IDX_COUNT);
			check("prescale", (v >= lo && v <= hi), 1'b1);
		end
	endtask

	// Five rising and four falling pin edges tell the two edge modes apart
	task automatic t_ext();
		for (int c = 6; c < 8; c++) begin
			wr(IDX_COUNT, 8'h00);
			wr(IDX_CTRL_B, c[7:0]);
			for (int i = 0; i < 5; i++) begin
				extCountPin <= 1'b1;
				repeat (4) @(posedge clock);
				if (i < 4) begin
					extCountPin <= 1'b0;
					repeat (4) @(posedge clock);
				end
			end
			repeat (6) @(posedge clock);
			wr(IDX_CTRL_B, 8'h00);
			rd(IDX_COUNT);
			check("pin edges", v, (c == 6) ? 8'h04 : 8'h05);
			extCountPin <= 1'b0;
			repeat (6) @(posedge clock);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock       = 1'b0;
		nrst        = 1'b0;
		wbCyc       = 1'b0;
		wbStb       = 1'b0;
		wbWe        = 1'b0;
		wbAdr       = 8'h00;
		wbSel       = 4'h0;
		wbWrData    = 32'h0;
		extCountPin = 1'b0;
		gie         = 1'b0;
		irqAck      = 3'b000;
		errCount    = 0;
		checked     = 0;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		t_regs();
		t_force();
		t_overflow();
		t_match();
		t_ctc();
		t_presc();
		t_ext();
		final_report();
	end
endmodule

// file: hw/tms_clock_select.sv
/*
 * Timer clock select: prescaler taps and count pin edge detect.
 * Assumes a synchronised reset; the count pin is asynchronous.
 */
`timescale 1ns/10ps
module tms_clock_select
	import tms_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rstN,
	// Control
	input  wire logic [2:0] clockSelect,
	input  wire logic       extCountPin,
	// Count enable pulse
	output logic            tick
);
	logic [PRE_WIDTH-1:0] preQ;
	logic [2:0]           pinSyncQ;
	logic                 pinRise;
	logic                 pinFall;

	// Free running; taps are shared so switching divisors has no reset
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			preQ <= '0;
		end else begin
			preQ <= preQ + 1'b1;
		end
	end

	// Stage 2 and 3 only feed the edge detect
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pinSyncQ <= 3'h0;
		end else begin
			pinSyncQ <= {pinSyncQ[1:0], extCountPin};
		end
	end

	assign pinRise = pinSyncQ[1] & ~pinSyncQ[2];
	assign pinFall = ~pinSyncQ[1] & pinSyncQ[2];

	always_comb begin
		unique case (clockSelect)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = &(preQ | ~PRE_MASK8);
			CS_DIV64:    tick = &(preQ | ~PRE_MASK64);
			CS_DIV256:   tick = &(preQ | ~PRE_MASK256);
			CS_DIV1024:  tick = &(preQ | ~PRE_MASK1024);
			CS_EXT_FALL: tick = pinFall;
			CS_EXT_RISE: tick = pinRise;
		endcase
	end
endmodule

// file: hw/tms_pkg.sv
/*
 * Constants shared by the timer 0 register block and its clock select.
 * Assumes a Wishbone bus with the register index in address bits 7:2.
 */
package tms_pkg;
	localparam int unsigned TMS_WIDTH   = 8;
	localparam int unsigned IRQ_COUNT   = 3;
	localparam int unsigned PRE_WIDTH   = 10;

	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_CTRL_B   = 6'h33;
	localparam logic [5:0] IDX_CTRL_A   = 6'h34;
	localparam logic [5:0] IDX_COUNT    = 6'h35;
	localparam logic [5:0] IDX_CMP_A    = 6'h36;
	localparam logic [5:0] IDX_FLAGS    = 6'h38;
	localparam logic [5:0] IDX_MASK     = 6'h39;
	localparam logic [5:0] IDX_CMP_B    = 6'h3c;

	// Control B fields
	localparam int unsigned CB_FORCE_A  = 7;
	localparam int unsigned CB_FORCE_B  = 6;
	localparam int unsigned CB_WAVE2    = 3;
	localparam int unsigned CB_CS_HI    = 2;
	// Control A fields
	localparam int unsigned CA_MODEA_LO = 6;
	localparam int unsigned CA_MODEB_LO = 4;
	localparam int unsigned CA_WAVE_HI  = 1;
	// Flag and mask bit positions
	localparam int unsigned IRQ_OVF     = 0;
	localparam int unsigned IRQ_CMPA    = 1;
	localparam int unsigned IRQ_CMPB    = 2;

	localparam logic [2:0] RST_CS       = 3'h0;
	localparam logic [1:0] RST_WAVE     = 2'h0;
	localparam logic [2:0] RST_IRQ      = 3'h0;

	// Clock select codes
	localparam logic [2:0] CS_STOP      = 3'h0;
	localparam logic [2:0] CS_DIV1      = 3'h1;
	localparam logic [2:0] CS_DIV8      = 3'h2;
	localparam logic [2:0] CS_DIV64     = 3'h3;
	localparam logic [2:0] CS_DIV256    = 3'h4;
	localparam logic [2:0] CS_DIV1024   = 3'h5;
	localparam logic [2:0] CS_EXT_FALL  = 3'h6;
	localparam logic [2:0] CS_EXT_RISE  = 3'h7;
	// Prescaler masks: tick when all masked bits are set
	localparam logic [PRE_WIDTH-1:0] PRE_MASK8    = 10'h007;
	localparam logic [PRE_WIDTH-1:0] PRE_MASK64   = 10'h03f;
	localparam logic [PRE_WIDTH-1:0] PRE_MASK256  = 10'h0ff;
	localparam logic [PRE_WIDTH-1:0] PRE_MASK1024 = 10'h3ff;

	// Waveform generation modes
	localparam logic [2:0] WM_NORMAL    = 3'h0;
	localparam logic [2:0] WM_PC_MAX    = 3'h1;
	localparam logic [2:0] WM_CTC       = 3'h2;
	localparam logic [2:0] WM_FAST_MAX  = 3'h3;
	localparam logic [2:0] WM_PC_TOP    = 3'h5;
	localparam logic [2:0] WM_FAST_TOP  = 3'h7;

	// Compare output modes
	localparam logic [1:0] OM_OFF       = 2'h0;
	localparam logic [1:0] OM_TOGGLE    = 2'h1;
	localparam logic [1:0] OM_CLEAR     = 2'h2;
	localparam logic [1:0] OM_SET       = 2'h3;
endpackage

// file: hw/tms_timer0.sv
/*
 * Timer 0 counter, compare, flag and mask logic with a Wishbone
 * classic slave. Assumes the CPU supplies a global interrupt enable
 * and one acknowledge pulse per vector taken, on the same clock.
 */
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
module tms_timer0
	import tms_pkg::*;
#(
	parameter int unsigned WIDTH = TMS_WIDTH
)
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// Wishbone slave
	input  wire logic                 wbCyc,
	input  wire logic                 wbStb,
	input  wire logic                 wbWe,
	input  wire logic [7:0]           wbAdr,
	input  wire logic [3:0]           wbSel,
	input  wire logic [31:0]          wbWrData,
	output logic      [31:0]          wbRdData,
	output logic                      wbAck,
	// External count pin
	input  wire logic                 extCountPin,
	// Compare outputs
	output logic                      compareOutA,
	output logic                      compareOutB,
	output logic                      compareOutAEn,
	output logic                      compareOutBEn,
	// Interrupt controller
	input  wire logic                 globalIrqEnable,
	input  wire logic [IRQ_COUNT-1:0] irqAck,
	output logic      [IRQ_COUNT-1:0] irqReq
);
	localparam logic [WIDTH-1:0] CNT_MAX    = '1;
	localparam logic [WIDTH-1:0] CNT_BOTTOM = '0;

	if (WIDTH < 2 || WIDTH > 8) begin : g_badWidth
		$error("tms_timer0: WIDTH must be 2 to 8");
	end

	////////////////////////////////////////////////////////////////////
	// Reset release

	logic [1:0] rstPipeQ;
	logic       rstN;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstPipeQ <= 2'h0;
		end else begin
			rstPipeQ <= {rstPipeQ[0], 1'b1};
		end
	end

	assign rstN = rstPipeQ[1];

	default clocking @(posedge clock); endclocking
	default disable iff (!rstN);

	////////////////////////////////////////////////////////////////////
	// Bus decode

	logic                 ackQ;
	logic [31:0]          rdDataQ;
	logic [31:0]          readData;
	logic                 busReq;
	logic                 busWr;
	logic [5:0]           wbIdx;
	logic [7:0]           wrByte;

	logic [2:0]           clockSelQ;
	logic                 wave2Q;
	logic [1:0]           wave10Q;
	logic [1:0]           outModeQ [2];
	logic [WIDTH-1:0]     cntQ;
	logic [WIDTH-1:0]     ocrQ [2];
	logic [IRQ_COUNT-1:0] flagsQ;
	logic [IRQ_COUNT-1:0] maskQ;

	assign busReq = wbCyc & wbStb & ~ackQ;
	assign busWr  = busReq & wbWe & wbSel[0];
	assign wbIdx  = wbAdr[7:2];
	assign wrByte = wbWrData[7:0];

	// Force bits and reserved bits are never stored
	always_comb begin
		readData = 32'h0;
		case (wbIdx)
			IDX_CTRL_B: readData = 32'({wave2Q, clockSelQ});
			IDX_CTRL_A: readData = 32'({outModeQ[0], outModeQ[1], 2'h0, wave10Q});
			IDX_COUNT:  readData = 32'(cntQ);
			IDX_CMP_A:  readData = 32'(ocrQ[0]);
			IDX_CMP_B:  readData = 32'(ocrQ[1]);
			IDX_FLAGS:  readData = 32'(flagsQ);
			IDX_MASK:   readData = 32'(maskQ);
			default:    readData = 32'h0;
		endcase
	end

	// One wait state; unmapped addresses still answer with zero
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			ackQ    <= 1'b0;
			rdDataQ <= 32'h0;
		end else begin
			ackQ    <= busReq;
			rdDataQ <= busReq ? readData : 32'h0;
		end
	end

	assign wbAck    = ackQ;
	assign wbRdData = rdDataQ;

	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("bus request not answered in one cycle");
	a_flags_reserved: assert property (wbAck && $past(wbIdx) == IDX_FLAGS |-> wbRdData[7:3] == 5'h0)
		else $error("reserved flag bits read nonzero");
	a_ctrlb_force_zero: assert property (wbAck && $past(wbIdx) == IDX_CTRL_B |-> wbRdData[7:4] == 4'h0)
		else $error("force or reserved bits read nonzero");

	////////////////////////////////////////////////////////////////////
	// Control registers

	logic wrCtrlB;
	logic wrCtrlA;
	logic wrCount;

	assign wrCtrlB = busWr & (wbIdx == IDX_CTRL_B);
	assign wrCtrlA = busWr & (wbIdx == IDX_CTRL_A);
	assign wrCount = busWr & (wbIdx == IDX_COUNT);

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			clockSelQ   <= RST_CS;
			wave2Q      <= 1'b0;
			wave10Q     <= RST_WAVE;
			outModeQ[0] <= OM_OFF;
			outModeQ[1] <= OM_OFF;
			maskQ       <= RST_IRQ;
		end else begin
			if (wrCtrlB) begin
				clockSelQ <= wrByte[CB_CS_HI:0];
				wave2Q    <= wrByte[CB_WAVE2];
			end
			if (wrCtrlA) begin
				outModeQ[0] <= wrByte[CA_MODEA_LO+:2];
				outModeQ[1] <= wrByte[CA_MODEB_LO+:2];
				wave10Q     <= wrByte[CA_WAVE_HI:0];
			end
			if (busWr && wbIdx == IDX_MASK) begin
				maskQ <= wrByte[IRQ_COUNT-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			ocrQ[0] <= '0;
			ocrQ[1] <= '0;
		end else begin
			// Compare values update at once in every mode
			if (busWr && wbIdx == IDX_CMP_A) begin
				ocrQ[0] <= wrByte[WIDTH-1:0];
			end
			if (busWr && wbIdx == IDX_CMP_B) begin
				ocrQ[1] <= wrByte[WIDTH-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode decode and timer clock

	logic [2:0]       waveMode;
	logic             nonPwm;
	logic             phaseCorrect;
	logic             fastPwm;
	logic [WIDTH-1:0] topValue;
	logic             tick;
	logic [1:0]       forcePulse;

	assign waveMode     = {wave2Q, wave10Q};
	assign nonPwm       = (waveMode == WM_NORMAL) | (waveMode == WM_CTC);
	assign phaseCorrect = (waveMode == WM_PC_MAX) | (waveMode == WM_PC_TOP);
	assign fastPwm      = (waveMode == WM_FAST_MAX) | (waveMode == WM_FAST_TOP);
	assign topValue     = (wave2Q | waveMode == WM_CTC) ? ocrQ[0] : CNT_MAX;

	// Pulse only in the accepting cycle, nothing kept
	assign forcePulse[0] = wrCtrlB & wrByte[CB_FORCE_A] & nonPwm;
	assign forcePulse[1] = wrCtrlB & wrByte[CB_FORCE_B] & nonPwm;

	tms_clock_select u_clockSelect (
		.clock       (clock),
		.rstN        (rstN),
		.clockSelect (clockSelQ),
		.extCountPin (extCountPin),
		.tick        (tick)
	);

	a_force_pwm_idle: assert property (!nonPwm |-> forcePulse == 2'h0)
		else $error("force pulse in a PWM mode");

	////////////////////////////////////////////////////////////////////
	// Counter

	logic             downQ;
	logic             blockQ;
	logic [1:0]       match;
	logic             overflow;
	logic             wrapBottom;

	// Forced events never touch the counter
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			cntQ  <= '0;
			downQ <= 1'b0;
		end else if (wrCount) begin
			cntQ <= wrByte[WIDTH-1:0];
		end else if (tick) begin
			if (!phaseCorrect) begin
				downQ <= 1'b0;
				cntQ  <= (cntQ == topValue) ? CNT_BOTTOM : cntQ + 1'b1;
			end else if (!downQ) begin
				downQ <= (cntQ == topValue);
				cntQ  <= (cntQ == topValue) ? cntQ - 1'b1 : cntQ + 1'b1;
			end else begin
				downQ <= (cntQ != CNT_BOTTOM);
				cntQ  <= (cntQ == CNT_BOTTOM) ? cntQ + 1'b1 : cntQ - 1'b1;
			end
		end
	end

	// Blocks the match on the first tick after a counter write
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			blockQ <= 1'b0;
		end else if (wrCount) begin
			blockQ <= 1'b1;
		end else if (tick) begin
			blockQ <= 1'b0;
		end
	end

	assign match[0] = tick & ~wrCount & ~blockQ & (cntQ == ocrQ[0]);
	assign match[1] = tick & ~wrCount & ~blockQ & (cntQ == ocrQ[1]);

	// Overflow point follows the wave mode
	always_comb begin
		overflow = 1'b0;
		if (tick && !wrCount) begin
			if (phaseCorrect) begin
				overflow = (cntQ == CNT_BOTTOM);
			end else if (waveMode == WM_FAST_TOP) begin
				overflow = (cntQ == topValue);
			end else begin
				overflow = (cntQ == CNT_MAX);
			end
		end
	end

	assign wrapBottom = tick & ~wrCount & fastPwm & (cntQ == topValue);

	a_write_blocks: assert property (wrCount |=> match == 2'h0)
		else $error("compare match right after counter write");
	a_ctc_clear: assert property (waveMode == WM_CTC && match[0] && !wrCount |=> cntQ == CNT_BOTTOM)
		else $error("CTC did not clear on compare A");

	////////////////////////////////////////////////////////////////////
	// Compare outputs

	logic [1:0] outQ;

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic outD;

		// Bottom wins in fast PWM, so a compare at TOP leaves bottom action
		always_comb begin
			outD = outQ[ch];
			if (nonPwm) begin
				if (match[ch] || forcePulse[ch]) begin
					unique case (outModeQ[ch])
						OM_OFF:    outD = outQ[ch];
						OM_TOGGLE: outD = ~outQ[ch];
						OM_CLEAR:  outD = 1'b0;
						OM_SET:    outD = 1'b1;
					endcase
				end
			end else if (outModeQ[ch][1]) begin
				if (fastPwm && wrapBottom) begin
					outD = ~outModeQ[ch][0];
				end else if (match[ch]) begin
					outD = downQ ? ~outModeQ[ch][0] : outModeQ[ch][0];
				end
			end
		end

		always_ff @(posedge clock or negedge rstN) begin
			if (!rstN) begin
				outQ[ch] <= 1'b0;
			end else begin
				outQ[ch] <= outD;
			end
		end
	end

	assign compareOutA   = outQ[0];
	assign compareOutB   = outQ[1];
	assign compareOutAEn = (outModeQ[0] != OM_OFF);
	assign compareOutBEn = (outModeQ[1] != OM_OFF);

	a_force_toggle: assert property (forcePulse[0] && !match[0] && outModeQ[0] == OM_TOGGLE
		|=> compareOutA != $past(compareOutA))
		else $error("forced toggle did not change output A");

	////////////////////////////////////////////////////////////////////
	// Flags and requests

	logic [IRQ_COUNT-1:0] flagSet;
	logic [IRQ_COUNT-1:0] flagClr;
	logic [IRQ_COUNT-1:0] irqReqQ;

	assign flagSet[IRQ_OVF]  = overflow;
	assign flagSet[IRQ_CMPA] = match[0];
	assign flagSet[IRQ_CMPB] = match[1];

	// Write one or vector acknowledge clears
	assign flagClr = irqAck | ({IRQ_COUNT{busWr && wbIdx == IDX_FLAGS}} & wrByte[IRQ_COUNT-1:0]);

	// A new event in the clearing cycle is kept
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			flagsQ <= RST_IRQ;
		end else begin
			flagsQ <= (flagsQ & ~flagClr) | flagSet;
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			irqReqQ <= RST_IRQ;
		end else begin
			irqReqQ <= flagsQ & maskQ & {IRQ_COUNT{globalIrqEnable}};
		end
	end

	assign irqReq = irqReqQ;

	a_force_no_flag: assert property (forcePulse[0] && !match[0] |=> !$rose(flagsQ[IRQ_CMPA]))
		else $error("forced compare set a flag");
	a_w1c_clears: assert property (flagClr[IRQ_OVF] && !flagSet[IRQ_OVF] |=> !flagsQ[IRQ_OVF])
		else $error("overflow flag not cleared");
	a_set_wins: assert property (flagSet[IRQ_CMPB] |=> flagsQ[IRQ_CMPB])
		else $error("compare B match lost");
	a_irq_gating: assert property (irqReq[IRQ_OVF] |-> $past(flagsQ[IRQ_OVF]) && $past(maskQ[IRQ_OVF])
		&& $past(globalIrqEnable))
		else $error("overflow request without its causes");
endmodule
